// ==== rtl/ind_osc_pkg.sv ====
// Contract
// - data window then address write stores data at the next update tick (16 kHz).
// - address write alone reads the location into the data window at the next tick.
// - data window is 16 bits, as two read/write bytes: low and high.
// - status bit 0 reads one while an indirect access is pending.
// - control bit 7 is read-only and shows oscillator signal active.
// - auto reload clear stops after inactive timer; set keeps cycling.
// - zero-cross bit clear ends signal at active expiry; set waits for zero crossing.
// - control bit 4 enables the active-period timer.
// - control bit 3 enables the inactive-period timer.
// - control bit 2 enables the oscillator.
// - route field 00 none, 01 transmit, 10 receive, 11 both.
// - completed indirect access sets serviced flag; writing one clears it.
// - serviced flag reaches interrupt output only when its enable is one.
package ind_osc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_DATA_LO = 8'h1C;
  localparam logic [7:0] ADDR_DATA_HI = 8'h1D;
  localparam logic [7:0] ADDR_IND_ADDR = 8'h1E;
  localparam logic [7:0] ADDR_IND_STAT = 8'h1F;
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h20;
  localparam logic [7:0] DATA_LO_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ==========================================================
  // oscillator control field positions
  localparam int CTRL_STATUS_BIT = 7;
  localparam int CTRL_RELOAD_BIT = 6;
  localparam int CTRL_ZC_BIT = 5;
  localparam int CTRL_ATE_BIT = 4;
  localparam int CTRL_ITE_BIT = 3;
  localparam int CTRL_EN_BIT = 2;
  localparam logic [1:0] ROUTE_NONE = 2'h0;
  localparam logic [1:0] ROUTE_TX = 2'h1;
  localparam logic [1:0] ROUTE_RX = 2'h2;
  localparam logic [1:0] ROUTE_BOTH = 2'h3;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 250_000_000;
  localparam int UPDATE_HZ = 16_000;
  localparam int UPDATE_CYCLES = CLK_HZ / UPDATE_HZ;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    OSC_OFF = 2'b00,
    OSC_ACTIVE = 2'b01,
    OSC_WAIT_ZC = 2'b10,
    OSC_SILENT = 2'b11
  } osc_state_t;

  typedef struct packed {
    logic autoReload;
    logic zeroCrossStop;
    logic activeTimerEn;
    logic inactiveTimerEn;
    logic enable;
    logic [1:0] routeSel;
  } osc_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wrEn;
    logic rdEn;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] dataWin;
    logic [7:0] indAddr;
    logic dataTouched;
    logic pending;
    logic isWrite;
    logic irqFlag;
    logic irqOut;
    osc_ctrl_t ctrl;
    osc_state_t osc;
    logic stopped;
    logic [15:0] timeCnt;
    logic routeTx;
    logic routeRx;
    logic [7:0] rdData;
  } blk_state_t;

endpackage : ind_osc_pkg

// ==== rtl/update_tick_gen.sv ====
`timescale 1ns/1ps
module update_tick_gen #(
  parameter int DIV = 15625
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // one-cycle update pulse
  output logic tick
);

  if (DIV < 2) begin : g_chk
    $error("update_tick_gen: DIV must be at least 2");
  end

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;

  // wrap at the last count so the pulse repeats every DIV cycles
  always_comb begin
    nxt_cnt = (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
  end

  // free-running divider, frozen while ce is low
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign tick = ce && (cnt_ff == LAST);

endmodule : update_tick_gen

// ==== rtl/ind_osc_ctrl.sv ====
`timescale 1ns/1ps
module ind_osc_ctrl
  import ind_osc_pkg::*;
#(
  parameter int TICK_CYCLES = UPDATE_CYCLES,
  parameter int TIMER_W = 16
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // register port, read data one cycle after rdEn
  input wire reg_req_t req,
  output logic [7:0] rdData,
  // serviced interrupt: enable, write-one clear, flag, output
  input wire logic irqServicedEn,
  input wire logic irqServicedClr,
  output logic irqServicedFlag,
  output logic irqOut,
  // oscillator datapath
  input wire logic [TIMER_W-1:0] activeLen,
  input wire logic [TIMER_W-1:0] inactiveLen,
  input wire logic zeroCross,
  output logic oscSignalActive,
  output logic routeTx,
  output logic routeRx
);

  if (TIMER_W < 1 || TIMER_W > 16) begin : g_chk
    $error("ind_osc_ctrl: TIMER_W must be 1..16");
  end

  // ==========================================================
  // update tick and indirect memory
  logic tick;
  logic [15:0] indMem [256];
  logic [15:0] memRd;
  blk_state_t st_ff;
  blk_state_t nxt_st;
  logic wrLo, wrHi, wrAddr, wrCtrl, commit, oscOn, activeExp, silentExp;

  update_tick_gen #(.DIV(TICK_CYCLES)) i_update_tick_gen (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .tick(tick)
  );

  assign memRd = indMem[st_ff.indAddr];
  assign commit = tick && st_ff.pending;

  always_ff @(posedge mclk) begin
    if (ce && commit && st_ff.isWrite) begin
      indMem[st_ff.indAddr] <= st_ff.dataWin;
    end
  end

  // ==========================================================
  // register decode
  assign wrLo = req.wrEn && (req.addr == ADDR_DATA_LO);
  assign wrHi = req.wrEn && (req.addr == ADDR_DATA_HI);
  assign wrAddr = req.wrEn && (req.addr == ADDR_IND_ADDR);
  assign wrCtrl = req.wrEn && (req.addr == ADDR_OSC_CTRL);
  assign oscOn = (st_ff.osc == OSC_ACTIVE) || (st_ff.osc == OSC_WAIT_ZC);
  assign activeExp = tick && st_ff.ctrl.activeTimerEn && (st_ff.timeCnt == '0);
  assign silentExp = tick && st_ff.ctrl.inactiveTimerEn && (st_ff.timeCnt == '0);

  // ==========================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    if (wrLo) begin
      nxt_st.dataWin[7:0] = req.wrData;
      nxt_st.dataTouched = 1'b1;
    end
    if (wrHi) begin
      nxt_st.dataWin[15:8] = req.wrData;
      nxt_st.dataTouched = 1'b1;
    end
    if (commit) begin
      nxt_st.pending = 1'b0;
      if (!st_ff.isWrite) begin
        nxt_st.dataWin = memRd;
      end
    end
    if (wrAddr) begin
      nxt_st.indAddr = req.wrData;
      nxt_st.pending = 1'b1;
      nxt_st.isWrite = st_ff.dataTouched || wrLo || wrHi;
      nxt_st.dataTouched = 1'b0;
    end
    if (irqServicedClr) begin
      nxt_st.irqFlag = 1'b0;
    end
    if (commit) begin
      nxt_st.irqFlag = 1'b1;
    end
    nxt_st.irqOut = nxt_st.irqFlag && irqServicedEn;
    if (wrCtrl) begin
      nxt_st.ctrl = req.wrData[6:0];
    end
    // oscillator sequencer
    unique case (st_ff.osc)
      OSC_OFF: begin
        if (st_ff.ctrl.enable && !st_ff.stopped) begin
          nxt_st.osc = OSC_ACTIVE;
          nxt_st.timeCnt = 16'(activeLen);
        end
      end
      OSC_ACTIVE: begin
        if (tick && st_ff.timeCnt != '0) begin
          nxt_st.timeCnt = st_ff.timeCnt - 1'b1;
        end
        if (activeExp) begin
          nxt_st.osc = st_ff.ctrl.zeroCrossStop ? OSC_WAIT_ZC : OSC_SILENT;
          nxt_st.timeCnt = 16'(inactiveLen);
        end
      end
      OSC_WAIT_ZC: begin
        if (zeroCross) begin
          nxt_st.osc = OSC_SILENT;
        end
      end
      OSC_SILENT: begin
        if (tick && st_ff.timeCnt != '0) begin
          nxt_st.timeCnt = st_ff.timeCnt - 1'b1;
        end
        if (silentExp) begin
          nxt_st.timeCnt = 16'(activeLen);
          nxt_st.osc = st_ff.ctrl.autoReload ? OSC_ACTIVE : OSC_OFF;
          nxt_st.stopped = !st_ff.ctrl.autoReload;
        end
      end
    endcase
    if (!st_ff.ctrl.enable) begin
      nxt_st.osc = OSC_OFF;
      nxt_st.stopped = 1'b0;
    end
    nxt_st.routeTx = (nxt_st.osc == OSC_ACTIVE || nxt_st.osc == OSC_WAIT_ZC) && nxt_st.ctrl.routeSel[0];
    nxt_st.routeRx = (nxt_st.osc == OSC_ACTIVE || nxt_st.osc == OSC_WAIT_ZC) && nxt_st.ctrl.routeSel[1];
    // register read mux, unmapped reads zero
    if (req.rdEn) begin
      unique case (req.addr)
        ADDR_DATA_LO: nxt_st.rdData = st_ff.dataWin[7:0];
        ADDR_DATA_HI: nxt_st.rdData = st_ff.dataWin[15:8];
        ADDR_IND_ADDR: nxt_st.rdData = st_ff.indAddr;
        ADDR_IND_STAT: nxt_st.rdData = {7'h00, st_ff.pending};
        ADDR_OSC_CTRL: nxt_st.rdData = {oscOn, st_ff.ctrl};
        default: nxt_st.rdData = READ_ZERO;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.dataWin[7:0] <= DATA_LO_RESET;
      st_ff.osc <= OSC_OFF;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign rdData = st_ff.rdData;
  assign irqServicedFlag = st_ff.irqFlag;
  assign irqOut = st_ff.irqOut;
  assign oscSignalActive = oscOn;
  assign routeTx = st_ff.routeTx;
  assign routeRx = st_ff.routeRx;

  // ==========================================================
  // checks
  pend_set_a: assert property (@(posedge mclk) disable iff (!nrst)
    ce && wrAddr |=> st_ff.pending)
    else $error("pending not set by address write");
  pend_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    st_ff.pending && !tick && !wrAddr |=> st_ff.pending)
    else $error("pending dropped before update tick");
  mem_store_a: assert property (@(posedge mclk) disable iff (!nrst)
    ce && commit && st_ff.isWrite |=> indMem[$past(st_ff.indAddr)] == $past(st_ff.dataWin))
    else $error("indirect write not stored");
  read_load_a: assert property (@(posedge mclk) disable iff (!nrst)
    ce && commit && !st_ff.isWrite && !wrLo && !wrHi |=> st_ff.dataWin == $past(memRd))
    else $error("indirect read not loaded");
  flag_set_a: assert property (@(posedge mclk) disable iff (!nrst)
    ce && commit && !wrAddr |=> st_ff.irqFlag && !st_ff.pending)
    else $error("serviced flag not set on completion");
  irq_mask_a: assert property (@(posedge mclk) disable iff (!nrst)
    irqOut |-> st_ff.irqFlag && $past(irqServicedEn))
    else $error("interrupt output not masked");
  osc_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    ce && !st_ff.ctrl.enable |=> st_ff.osc == OSC_OFF)
    else $error("oscillator runs while disabled");
  zc_wait_a: assert property (@(posedge mclk) disable iff (!nrst)
    ce && st_ff.osc == OSC_ACTIVE && activeExp && st_ff.ctrl.enable && st_ff.ctrl.zeroCrossStop
    |=> st_ff.osc == OSC_WAIT_ZC)
    else $error("zero-cross wait skipped");
  active_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    ce && st_ff.osc == OSC_ACTIVE && st_ff.ctrl.enable && !st_ff.ctrl.activeTimerEn
    |=> st_ff.osc == OSC_ACTIVE)
    else $error("active period ended with its timer off");
  silent_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    ce && st_ff.osc == OSC_SILENT && st_ff.ctrl.enable && !st_ff.ctrl.inactiveTimerEn
    |=> st_ff.osc == OSC_SILENT)
    else $error("silent period ended with its timer off");
  reload_stop_a: assert property (@(posedge mclk) disable iff (!nrst)
    st_ff.osc == OSC_SILENT && silentExp && st_ff.ctrl.enable && !st_ff.ctrl.autoReload
    |=> st_ff.osc == OSC_OFF && st_ff.stopped)
    else $error("oscillator kept running without reload");
  route_tx_a: assert property (@(posedge mclk) disable iff (!nrst)
    routeTx |-> oscOn && st_ff.ctrl.routeSel[0])
    else $error("transmit route wrong");
  stat_read_a: assert property (@(posedge mclk) disable iff (!nrst)
    ce && req.rdEn && req.addr == ADDR_OSC_CTRL |=> rdData[CTRL_STATUS_BIT] == $past(oscOn))
    else $error("status bit wrong on read");

endmodule : ind_osc_ctrl

// ==== bench/indirect_access_tone_osc_ctrl_tb_top.sv ====
`timescale 1ns/1ps
module indirect_access_tone_osc_ctrl_tb_top
  import ind_osc_pkg::*;
;
  // ==========================================================
  // stimulus and observed signals
  localparam int TICKS = 8;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  reg_req_t req = '0;
  logic irqServicedEn = 1'b1;
  logic irqServicedClr = 1'b0;
  logic [15:0] activeLen = 16'h0001;
  logic [15:0] inactiveLen = 16'h0001;
  logic zeroCross = 1'b0;
  logic [7:0] rdData;
  logic irqServicedFlag, irqOut, oscSignalActive, routeTx, routeRx;
  int errorCnt = 0;
  int nTests = 0;
  int falls;

  // 250 MHz clock
  always #2 mclk = ~mclk;

  ind_osc_ctrl #(.TICK_CYCLES(TICKS), .TIMER_W(16)) i_ind_osc_ctrl (
    .mclk(mclk), .nrst(nrst), .ce(ce), .req(req), .rdData(rdData),
    .irqServicedEn(irqServicedEn), .irqServicedClr(irqServicedClr),
    .irqServicedFlag(irqServicedFlag), .irqOut(irqOut),
    .activeLen(activeLen), .inactiveLen(inactiveLen), .zeroCross(zeroCross),
    .oscSignalActive(oscSignalActive), .routeTx(routeTx), .routeRx(routeRx)
  );

  // ==========================================================
  // verdict and comparisons
  task automatic end_of_test();
    $display("checks %0d errors %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] seen);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk8

  task automatic chk1(input string name, input logic exp, input logic seen);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("Error %s expected %b seen %b", name, exp, seen);
    end
  endtask : chk1

  // ==========================================================
  // register port cycles, driven on the falling edge
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge mclk);
    req = '{addr: addr, wrData: data, wrEn: 1'b1, rdEn: 1'b0};
    @(negedge mclk);
    req.wrEn = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input string name);
    @(negedge mclk);
    req = '{addr: addr, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
    @(negedge mclk);
    req.rdEn = 1'b0;
    @(negedge mclk);
    chk8(name, exp, rdData);
  endtask : rd

  // wait for the serviced flag, bounded by a few update periods
  task automatic wait_flag();
    int i;
    for (i = 0; i < 3 * TICKS; i++) begin
      @(negedge mclk);
      if (irqServicedFlag === 1'b1) break;
    end
    if (i == 3 * TICKS) begin
      errorCnt++;
      $display("Error serviced flag expected 1 seen %b", irqServicedFlag);
      end_of_test();
    end
  endtask : wait_flag

  // write-one clear of the serviced flag
  task automatic clr_flag();
    @(negedge mclk);
    irqServicedClr = 1'b1;
    @(negedge mclk);
    irqServicedClr = 1'b0;
  endtask : clr_flag

  task automatic count_falls(input int cyc);
    logic prev;
    prev = oscSignalActive;
    falls = 0;
    repeat (cyc) begin
      @(negedge mclk);
      if (prev === 1'b1 && oscSignalActive === 1'b0) falls++;
      prev = oscSignalActive;
    end
  endtask : count_falls

  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    rd(ADDR_DATA_LO, DATA_LO_RESET, "dataLo");
    rd(ADDR_IND_STAT, 8'h00, "status");
    rd(8'h21, READ_ZERO, "unmapped");
    wr(ADDR_DATA_LO, 8'h5A);
    wr(ADDR_DATA_HI, 8'hC3);
    rd(ADDR_DATA_HI, 8'hC3, "dataHi");
    wr(ADDR_IND_ADDR, 8'hFF);
    wait_flag();
    chk1("irqOut", 1'b1, irqOut);
    clr_flag();
    wr(ADDR_DATA_HI, 8'h80);
    wr(ADDR_DATA_LO, 8'h01);
    wr(ADDR_IND_ADDR, 8'h00);
    wait_flag();
    clr_flag();
    wr(ADDR_IND_ADDR, 8'hFF);
    rd(ADDR_IND_STAT, 8'h01, "pending");
    chk1("flagCleared", 1'b0, irqServicedFlag);
    chk1("irqOutCleared", 1'b0, irqOut);
    wait_flag();
    rd(ADDR_IND_STAT, 8'h00, "idle");
    rd(ADDR_DATA_LO, 8'h5A, "readLo");
    rd(ADDR_DATA_HI, 8'hC3, "readHi");
    rd(ADDR_IND_ADDR, 8'hFF, "indAddr");
    clr_flag();
    irqServicedEn = 1'b0;
    wr(ADDR_IND_ADDR, 8'h00);
    // clock enable low freezes the pending access and the tick divider
    ce = 1'b0;
    repeat (3 * TICKS) @(negedge mclk);
    chk1("frozenFlag", 1'b0, irqServicedFlag);
    ce = 1'b1;
    wait_flag();
    chk1("irqMasked", 1'b0, irqOut);
    rd(ADDR_DATA_LO, 8'h01, "readLo2");
    rd(ADDR_DATA_HI, 8'h80, "readHi2");
    wr(ADDR_IND_STAT, 8'hFF);
    rd(ADDR_IND_STAT, 8'h00, "statusRo");
    wr(ADDR_OSC_CTRL, 8'h80);
    rd(ADDR_OSC_CTRL, 8'h00, "ctrlRo");
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_OSC_CTRL, 8'h04 | r[7:0]);
      repeat (3 * TICKS) @(negedge mclk);
      rd(ADDR_OSC_CTRL, 8'h84 | r[7:0], "ctrlOn");
      chk1("routeTx", r[0], routeTx);
      chk1("routeRx", r[1], routeRx);
      chk1("oscHolds", 1'b1, oscSignalActive);
    end
    wr(ADDR_OSC_CTRL, 8'h03);
    rd(ADDR_OSC_CTRL, 8'h03, "ctrlOff");
    chk1("routeOff", 1'b0, routeTx);
    activeLen = 16'h0002;
    wr(ADDR_OSC_CTRL, 8'h54);
    repeat (TICKS - 2) @(negedge mclk);
    chk1("stillActive", 1'b1, oscSignalActive);
    count_falls(10 * TICKS);
    chk1("oneExpiry", 1'b1, falls == 1);
    rd(ADDR_OSC_CTRL, 8'h54, "ctrlSilent");
    activeLen = 16'h0001;
    wr(ADDR_OSC_CTRL, 8'h00);
    wr(ADDR_OSC_CTRL, 8'h34);
    repeat (5 * TICKS) @(negedge mclk);
    chk1("waitZero", 1'b1, oscSignalActive);
    zeroCross = 1'b1;
    @(negedge mclk);
    zeroCross = 1'b0;
    repeat (2) @(negedge mclk);
    chk1("zeroStop", 1'b0, oscSignalActive);
    wr(ADDR_OSC_CTRL, 8'h00);
    wr(ADDR_OSC_CTRL, 8'h5C);
    count_falls(20 * TICKS);
    chk1("cadence", 1'b1, falls >= 3);
    wr(ADDR_OSC_CTRL, 8'h00);
    wr(ADDR_OSC_CTRL, 8'h1C);
    count_falls(20 * TICKS);
    chk1("noReload", 1'b1, falls == 1);
    chk1("stopped", 1'b0, oscSignalActive);
    end_of_test();
  end

endmodule : indirect_access_tone_osc_ctrl_tb_top
